// >>> logic/dis_sec_tick.sv
// whole-second tick generator
// assumes mclk at the package rate
`timescale 1ns/1ns
`default_nettype none
module dis_sec_tick
  import dis_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // one-cycle pulse per second
  output logic tick
);
  logic [26:0] cnt;

  // free running divider
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cnt <= '0;
      tick <= 1'b0;
    end else if (cnt == 27'(SEC_CYCLES - 1)) begin
      cnt <= '0;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 27'h1;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> logic/dis_supervisor.sv
// supervisory control: trip restart, spinning catch, idle stop, pwm limits
// assumes settings are stable words from same clock; pins are async
// assumes the drive stage applies ramps, braking and the current derate
// assumes trip_event, catch_done and brake_done come from logic on mclk
`timescale 1ns/1ns
`default_nettype none
module dis_supervisor
  import dis_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // settings from panel or serial link
  input wire dis_cfg_t cfg,
  // async pins
  input wire logic panel_reset_key,
  input wire logic reset_input,
  input wire logic start_cmd,
  input wire logic local_ref,
  input wire logic jog,
  // drive stage status, same clock
  input wire logic trip_event,
  input wire logic catch_done,
  input wire logic brake_done,
  input wire logic [15:0] theo_freq,
  input wire logic [15:0] actual_freq,
  input wire logic [15:0] motor_speed,
  // drive stage commands
  output logic tripped,
  output logic trip_clear,
  output logic run_enable,
  output logic catch_req,
  output logic brake_req,
  output logic catch_fail,
  output logic ramp_down,
  output logic idle_active,
  output logic [15:0] freq_target,
  output logic [15:0] freq_cap,
  output logic [15:0] boost_pct,
  output logic [15:0] active_pwm_rate,
  output logic derate,
  output logic [4:0] attempts_used
);
  // derived policy limit
  logic [4:0] max_tries;
  logic unlimited;
  // second tick and synchronised pins
  logic tick;
  logic [4:0] pins_s;
  logic man_reset, start_s, local_s, jog_s, start_d;
  logic start_rise;
  // trip retry state
  logic [9:0] retry_cnt;
  logic exhausted;
  // idle timer state
  logic [8:0] idle_cnt;
  logic [8:0] idle_lim;
  // retry delay after its range clamp
  logic [9:0] retry_lim;
  logic idle_ok;
  logic [15:0] entry_f, wake_f;
  // catch sequencer state
  typedef enum logic [1:0] {C_IDLE, C_BRAKE, C_CATCH, C_RUN} cstate_t;
  cstate_t cst;

  // policy decode
  // codes above nine give no tries and are not unlimited, so an illegal
  // code behaves like a policy whose attempts are already used up
  function automatic logic [4:0] tries_of(input logic [3:0] code);
    if (code == POL_X10) tries_of = TRIES_10;
    else if (code == POL_X15) tries_of = TRIES_15;
    else if (code == POL_X20) tries_of = TRIES_20;
    else if (code <= POL_X5) tries_of = {1'b0, code};
    else tries_of = '0;
  endfunction

  // clamp helper for settings
  // out-of-range settings are pulled to the nearest end, never refused
  function automatic logic [15:0] clamp16(input logic [15:0] v,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
    if (v < lo) clamp16 = lo;
    else if (v > hi) clamp16 = hi;
    else clamp16 = v;
  endfunction

  // policy 0 yields no tries; the trip latch treats it as manual
  assign max_tries = tries_of(cfg.restart_policy);
  assign unlimited = (cfg.restart_policy == POL_INFINITE);

  // one free-running tick serves the retry delay and the idle timer
  dis_sec_tick u_tick (
    .mclk(mclk),
    .rstn(rstn),
    .tick(tick)
  );

  // pins pass two flops before any logic reads them
  dis_sync #(.W(5)) u_sync (
    .mclk(mclk),
    .rstn(rstn),
    .din({panel_reset_key, reset_input, start_cmd, local_ref, jog}),
    .dout(pins_s)
  );
  // key and reset input are merged after sync; either clears a trip
  // all five pins lag their pads by two clock edges
  assign man_reset = pins_s[4] | pins_s[3];
  assign start_s = pins_s[2];
  assign local_s = pins_s[1];
  assign jog_s = pins_s[0];

  // start edge for catch
  // start_d resets low like the synchronised pins, so reset makes no false edge
  always_ff @(posedge mclk) begin
    if (!rstn) start_d <= 1'b0;
    else start_d <= start_s;
  end
  assign start_rise = start_s & ~start_d;

  // retry delay limited to range
  // a delay above the top of the range is held at the top
  assign retry_lim = (cfg.trip_retry_delay > RETRY_MAX_S) ?
                     RETRY_MAX_S : cfg.trip_retry_delay;

  // trip latch; a new trip wins over a clear in the same cycle
  // the tick runs free, so the first counted second of a retry delay may
  // fall short by up to a second; a zero delay clears on the next edge
  // attempts return to zero only on a manual reset, so sparse trips over
  // a long run add up; this keeps a recurring fault from restarting forever
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      tripped <= 1'b0;
      trip_clear <= 1'b0;
      retry_cnt <= '0;
      attempts_used <= '0;
      exhausted <= 1'b0;
    end else begin
      trip_clear <= 1'b0;
      // a repeat trip while tripped restarts the delay
      if (trip_event) begin
        tripped <= 1'b1;
        retry_cnt <= '0;
      end else if (tripped) begin
        if (man_reset) begin
          tripped <= 1'b0;
          trip_clear <= 1'b1;
          attempts_used <= '0;
          exhausted <= 1'b0;
        // stay tripped once tries run out
        // exhausted only falls on a manual reset
        end else if (cfg.restart_policy == POL_MANUAL || exhausted) begin
          retry_cnt <= '0;
        // attempt count limit
        // checked before the delay so no attempt slips past the limit
        end else if (!unlimited && attempts_used >= max_tries) begin
          exhausted <= 1'b1;
        end else if (retry_cnt >= retry_lim) begin
          tripped <= 1'b0;
          trip_clear <= 1'b1;
          retry_cnt <= '0;
          if (!unlimited) attempts_used <= attempts_used + 5'h1;
        end else if (tick) begin
          retry_cnt <= retry_cnt + 10'h1;
        end
      end else if (man_reset) begin
        attempts_used <= '0;
        exhausted <= 1'b0;
      end
    end
  end

  // thresholds held in their ranges
  // wake is clamped first so entry never sits above it, whatever the
  // order in which the two settings were written
  assign wake_f = clamp16(cfg.wake_threshold, cfg.idle_entry,
                          cfg.output_freq_upper_limit);
  assign entry_f = clamp16(cfg.idle_entry, ENTRY_DEF, wake_f);

  // 301 or above is off
  // any larger value also reads as off, so no stray setting starts a sleep
  assign idle_lim = cfg.idle_timer;
  // local or jog inhibits; loop mode not consulted
  // local or jog also clears a running timer and wakes an idle drive
  assign idle_ok = (idle_lim < IDLE_OFF_S) && !local_s && !jog_s;

  // whole-second idle timer
  // the timer only runs with start held and no trip standing, so a stop
  // or a trip leaves no part-counted time behind
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      idle_cnt <= '0;
      idle_active <= 1'b0;
    end else if (!idle_ok || tripped || !start_s) begin
      idle_cnt <= '0;
      idle_active <= 1'b0;
    end else if (idle_active) begin
      // wake on theoretical above wake threshold
      // waking also restarts the timer from zero
      if (theo_freq > wake_f) begin
        idle_active <= 1'b0;
        idle_cnt <= '0;
      end
    // rise above entry resets timer
    // exactly at the threshold counts as risen
    end else if (actual_freq >= entry_f) begin
      idle_cnt <= '0;
    // count while below entry
    // expiry is tested before the tick, so a zero timer stops at once
    end else if (idle_cnt >= idle_lim) begin
      idle_active <= 1'b1;
    end else if (tick) begin
      idle_cnt <= idle_cnt + 9'h1;
    end
  end
  // ramp-down time applied by the drive stage
  // the level holds until a wake, a stop, a trip or an inhibit
  assign ramp_down = idle_active;

  // pwm source
  // every other method falls back to the default rate word
  always_comb begin
    if (cfg.noise_method == NOISE_FIXED) active_pwm_rate = cfg.inverter_pwm_rate;
    else active_pwm_rate = cfg.default_pwm_rate;
  end
  // derate flag
  // the stage lowers its current; the frequency path is left alone
  assign derate = (active_pwm_rate > PWM_DERATE_HZ);

  // spinning catch sequencer
  // a trip drops back to idle; the clear term below restarts the drive
  // after a reset while start is still held, as no new start edge comes
  // then and the drive would otherwise stay stopped
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cst <= C_IDLE;
      catch_fail <= 1'b0;
    end else if (!start_s || tripped) begin
      cst <= C_IDLE;
    end else begin
      unique case (cst)
        C_IDLE: begin
          // on start edge or trip clear
          if (start_rise || trip_clear) begin
            catch_fail <= 1'b0;
            // mode decode; brake needs brake enabled
            // mode 2 without brake enabled starts straight away
            if (cfg.catch_mode == CATCH_BRAKE && cfg.dc_brake_enabled)
              cst <= C_BRAKE;
            else if (cfg.catch_mode == CATCH_ON)
              cst <= C_CATCH;
            else
              cst <= C_RUN;
          end
        end
        C_BRAKE: begin
          // dc brake until the stage reports it done
          if (brake_done) cst <= C_RUN;
        end
        C_CATCH: begin
          // catch only below upper limit
          // a failed catch still runs, with catch_fail left for the stage
          if (motor_speed >= cfg.output_freq_upper_limit) begin
            catch_fail <= 1'b1;
            cst <= C_RUN;
          end else if (catch_done) begin
            cst <= C_RUN;
          end
        end
        // run holds until start drops or a trip stands
        C_RUN: cst <= C_RUN;
      endcase
    end
  end
  // requests stand as levels until the stage answers
  assign catch_req = (cst == C_CATCH);
  assign brake_req = (cst == C_BRAKE);
  // idle holds run off so the stage ramps down and stays stopped
  assign run_enable = (cst == C_RUN) && !idle_active;

  // boost only in closed loop, within range
  // only the percentage travels; the regulator scales its own reference
  always_ff @(posedge mclk) begin
    if (!rstn) boost_pct <= {8'h00, BOOST_UNITY};
    else if (!cfg.closed_loop) boost_pct <= {8'h00, BOOST_UNITY};
    else boost_pct <= clamp16({8'h00, cfg.boost_pct}, {8'h00, BOOST_MIN},
                              {8'h00, BOOST_MAX});
  end

  // frequency target and clamp
  // a pwm rate in Hz read as 0.1 Hz counts is exactly one tenth of it, so
  // the rate word serves as the cap with no divider
  always_ff @(posedge mclk) begin
    logic [15:0] cap;
    cap = '0;
    if (!rstn) begin
      freq_target <= '0;
      freq_cap <= '0;
    end else begin
      // a tenth of pwm rate, 0.1 Hz units equal Hz/10*10
      cap = (active_pwm_rate < cfg.output_freq_upper_limit) ?
            active_pwm_rate : cfg.output_freq_upper_limit;
      freq_cap <= cap;
      // stopped in idle: target zero while the stage ramps down
      if (idle_active)
        freq_target <= '0;
      // track theoretical down to lower limit
      // below the lower limit the target holds at the limit
      else if (theo_freq < cfg.output_freq_lower_limit)
        freq_target <= cfg.output_freq_lower_limit;
      else if (theo_freq > cap)
        freq_target <= cap;
      else
        freq_target <= theo_freq;
    end
  end
endmodule
`default_nettype wire

// >>> logic/dis_sync.sv
// two flip-flop synchroniser for pin inputs
// assumes asynchronous level inputs
`timescale 1ns/1ns
`default_nettype none
module dis_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // async in, synced out
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta;

  // first stage read only by second
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule
`default_nettype wire

// >>> shared/dis_pkg.sv
// package for the idle-stop and auto-restart supervisor
// assumes frequencies in 0.1 Hz units and pwm rate in Hz
package dis_pkg;
  // clock and second tick
  localparam int CLK_HZ = 100000000;
  localparam int SEC_CYCLES = CLK_HZ;
  // restart policy codes
  localparam logic [3:0] POL_MANUAL = 4'h0;
  localparam logic [3:0] POL_X5 = 4'h5;
  localparam logic [3:0] POL_X10 = 4'h6;
  localparam logic [3:0] POL_X15 = 4'h7;
  localparam logic [3:0] POL_X20 = 4'h8;
  localparam logic [3:0] POL_INFINITE = 4'h9;
  localparam logic [4:0] TRIES_10 = 5'h0A;
  localparam logic [4:0] TRIES_15 = 5'h0F;
  localparam logic [4:0] TRIES_20 = 5'h14;
  // retry delay in seconds
  localparam logic [9:0] RETRY_MAX_S = 10'h258;
  localparam logic [9:0] RETRY_DEF_S = 10'h00A;
  // idle timer in seconds
  localparam logic [8:0] IDLE_MAX_S = 9'h12C;
  localparam logic [8:0] IDLE_OFF_S = 9'h12D;
  // frequencies, 0.1 Hz per lsb
  localparam logic [15:0] ENTRY_DEF = 16'h0000;
  localparam logic [15:0] WAKE_DEF = 16'h01F4;
  // boost in percent
  localparam logic [7:0] BOOST_MIN = 8'h01;
  localparam logic [7:0] BOOST_MAX = 8'hC8;
  localparam logic [7:0] BOOST_UNITY = 8'h64;
  // pwm rate in Hz
  localparam logic [15:0] PWM_DERATE_HZ = 16'h1194;
  localparam logic [1:0] NOISE_FIXED = 2'h1;
  // spinning catch codes
  typedef enum logic [1:0] {
    CATCH_OFF = 2'h0,
    CATCH_ON = 2'h1,
    CATCH_BRAKE = 2'h2
  } dis_catch_t;
  // settings group
  typedef struct packed {
    logic [3:0] restart_policy;
    logic [9:0] trip_retry_delay;
    logic [1:0] catch_mode;
    logic [8:0] idle_timer;
    logic [15:0] idle_entry;
    logic [15:0] wake_threshold;
    logic [7:0] boost_pct;
    logic [15:0] output_freq_upper_limit;
    logic [15:0] output_freq_lower_limit;
    logic [15:0] inverter_pwm_rate;
    logic [15:0] default_pwm_rate;
    logic [1:0] noise_method;
    logic closed_loop;
    logic dc_brake_enabled;
  } dis_cfg_t;
endpackage

// >>> verification/dis_stage_model.sv
// drive stage model answering catch and brake requests
// assumes requests stand as levels until answered
`timescale 1ns/1ns
`default_nettype none
module dis_stage_model #(
  parameter int LAT = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // requests and answers
  input wire logic catch_req,
  input wire logic brake_req,
  output logic catch_done,
  output logic brake_done
);
  int cnt;
  // slow answer so a request is seen standing
  always_ff @(posedge mclk) begin
    if (!rstn || !(catch_req || brake_req)) begin
      cnt <= 0;
    end else if (cnt < LAT) begin
      cnt <= cnt + 1;
    end
  end
  // done only while its request stands
  assign catch_done = catch_req && cnt == LAT;
  assign brake_done = brake_req && cnt == LAT;
endmodule
`default_nettype wire

// >>> verification/dis_supervisor_props.sv
// assertions on the supervisor ports
// assumes a bind into dis_supervisor, one clock
`timescale 1ns/1ns
`default_nettype none
module dis_supervisor_props
  import dis_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // inputs watched
  input wire dis_cfg_t cfg,
  input wire logic panel_reset_key,
  input wire logic reset_input,
  input wire logic local_ref,
  input wire logic jog,
  input wire logic trip_event,
  // outputs watched
  input wire logic tripped,
  input wire logic trip_clear,
  input wire logic idle_active,
  input wire logic [15:0] freq_cap,
  input wire logic [15:0] active_pwm_rate,
  input wire logic derate,
  input wire logic [4:0] attempts_used
);
  // single domain
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  property p_trip_set;
    trip_event |=> tripped;
  endproperty
  a_trip_set: assert property (p_trip_set)
    else $error("trip not latched");
  property p_clear;
    trip_clear |-> !tripped && $past(tripped) ##1 !trip_clear;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear pulse malformed");
  // manual never self-clears; sync lag covered
  property p_manual;
    (cfg.restart_policy == POL_MANUAL && !panel_reset_key
      && !reset_input) [*4] |-> !trip_clear;
  endproperty
  a_manual: assert property (p_manual)
    else $error("manual policy cleared alone");
  property p_tries;
    cfg.restart_policy inside {[1:5]}
      |-> attempts_used <= {1'b0, cfg.restart_policy};
  endproperty
  a_tries: assert property (p_tries)
    else $error("too many attempts");
  property p_pwm_sel;
    active_pwm_rate == ((cfg.noise_method == NOISE_FIXED)
      ? cfg.inverter_pwm_rate : cfg.default_pwm_rate);
  endproperty
  a_pwm_sel: assert property (p_pwm_sel)
    else $error("wrong pwm rate source");
  property p_derate;
    derate == (active_pwm_rate > PWM_DERATE_HZ);
  endproperty
  a_derate: assert property (p_derate)
    else $error("derate wrong");
  property p_cap;
    $stable(cfg) && cfg == $past(cfg, 2) |-> freq_cap <= active_pwm_rate
      && freq_cap <= cfg.output_freq_upper_limit;
  endproperty
  a_cap: assert property (p_cap)
    else $error("frequency cap too high");
  property p_inhibit;
    (local_ref || jog) [*4] |-> !idle_active;
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("idle under local or jog");
  property p_idle_off;
    cfg.idle_timer == IDLE_OFF_S && !idle_active |=> !idle_active;
  endproperty
  a_idle_off: assert property (p_idle_off)
    else $error("idle entered while off");
endmodule
`default_nettype wire

// >>> verification/dis_supervisor_test.sv
// self-checking bench for the supervisor
// assumes retry delay 0 clears without a second tick
`timescale 1ns/1ns
`default_nettype none
module dis_supervisor_test
  import dis_pkg::*;
;
  logic mclk = 1'b0;
  logic rstn, panel_reset_key, reset_input, start_cmd, local_ref, jog;
  logic trip_event, catch_done, brake_done, seen;
  logic tripped, trip_clear, run_enable, catch_req, brake_req, catch_fail;
  logic ramp_down, idle_active, derate;
  logic [15:0] theo_freq, actual_freq, motor_speed, freq_target, freq_cap;
  logic [15:0] boost_pct, active_pwm_rate, exp_rate;
  logic [4:0] attempts_used;
  dis_cfg_t cfg;
  int n_fail = 0, checks = 0, cycles = 0, n, clears;
  dis_supervisor u_dis_supervisor (.mclk, .rstn, .cfg, .panel_reset_key,
    .reset_input, .start_cmd, .local_ref, .jog, .trip_event, .catch_done,
    .brake_done, .theo_freq, .actual_freq, .motor_speed, .tripped,
    .trip_clear, .run_enable, .catch_req, .brake_req, .catch_fail,
    .ramp_down, .idle_active, .freq_target, .freq_cap, .boost_pct,
    .active_pwm_rate, .derate, .attempts_used);
  dis_stage_model u_dis_stage_model (.mclk, .rstn, .catch_req, .brake_req,
    .catch_done, .brake_done);
  // clock and hang guard
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (n_fail == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] e, g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge mclk);
  endtask
  task automatic do_reset();
    rstn = 1'b0;
    cyc(20);
    rstn = 1'b1;
    cyc(1);
  endtask
  task automatic trip();
    trip_event = 1'b1;
    cyc(1);
    trip_event = 1'b0;
  endtask
  // bounded wait; 0 clear, 1 catch, 2 brake, 3 idle, 4 awake, 5 fail
  task automatic wait_for(input int which, lim, output logic s);
    s = 1'b0;
    for (int i = 0; i < lim && s !== 1'b1; i++) begin
      @(negedge mclk);
      case (which)
        0: s = trip_clear;
        1: s = catch_req;
        2: s = brake_req;
        3: s = idle_active;
        4: s = !idle_active;
        default: s = catch_fail;
      endcase
    end
  endtask
  initial begin
    cfg = '0;
    cfg.idle_timer = IDLE_OFF_S;
    cfg.wake_threshold = WAKE_DEF;
    cfg.boost_pct = BOOST_UNITY;
    cfg.output_freq_upper_limit = 16'h1190;
    cfg.inverter_pwm_rate = 16'h1194;
    cfg.default_pwm_rate = 16'h0FA0;
    cfg.dc_brake_enabled = 1'b1;
    {panel_reset_key, reset_input, start_cmd, local_ref, jog} = '0;
    trip_event = 1'b0;
    {theo_freq, actual_freq, motor_speed} = '0;
    do_reset();
    chk("tripped", 16'h0, 16'(tripped));
    chk("boost", 16'h0064, boost_pct);
    // pwm source, cap and derate table
    for (int i = 0; i < 4; i++) begin
      cfg.noise_method = (i == 0) ? 2'h0 : (i == 2) ? 2'h2 : 2'h1;
      cfg.inverter_pwm_rate = (i == 3) ? 16'h1195 : 16'h1194;
      cyc(3);
      exp_rate = (i % 2) ? cfg.inverter_pwm_rate : cfg.default_pwm_rate;
      chk("pwm", exp_rate, active_pwm_rate);
      chk("derate", 16'(exp_rate > 16'h1194), 16'(derate));
      chk("cap", (exp_rate < 16'h1190) ? exp_rate : 16'h1190, freq_cap);
    end
    cfg.closed_loop = 1'b1;
    // in range, below range, above range
    for (int b = 0; b < 3; b++) begin
      cfg.boost_pct = (b == 0) ? 8'h7D : (b == 1) ? 8'h00 : 8'hFA;
      exp_rate = (b == 0) ? 16'h007D : (b == 1) ? 16'h0001 : 16'h00C8;
      cyc(3);
      chk("boost", exp_rate, boost_pct);
    end
    // manual policy: key then input
    for (int j = 0; j < 2; j++) begin
      trip();
      cyc(60);
      chk("manual hold", 16'h1, 16'(tripped));
      if (j == 0) panel_reset_key = 1'b1;
      else reset_input = 1'b1;
      wait_for(0, 10, seen);
      chk("manual clear", 16'h1, 16'(seen));
      {panel_reset_key, reset_input} = '0;
      cyc(5);
    end
    // every automatic code, one more trip than allowed
    for (int c = 1; c < 10; c++) begin
      do_reset();
      cfg.restart_policy = 4'(c);
      cyc(2);
      n = (c < 6) ? c : (c == 6) ? 10 : (c == 7) ? 15 : (c == 8) ? 20 : 25;
      clears = 0;
      for (int k = 0; k <= n; k++) begin
        trip();
        wait_for(0, 40, seen);
        if (seen === 1'b1) clears++;
        cyc(2);
      end
      chk("clears", 16'((c == 9) ? n + 1 : n), 16'(clears));
      chk("stuck", 16'(c != 9), 16'(tripped));
      if (c != 9) chk("attempts", 16'(n), 16'(attempts_used));
    end
    cfg.restart_policy = POL_MANUAL;
    do_reset();
    // catch modes off, on, brake-first, brake-first with brake disabled
    for (int m = 0; m < 4; m++) begin
      cfg.catch_mode = 2'((m == 3) ? 2 : m);
      cfg.dc_brake_enabled = (m != 3);
      start_cmd = 1'b1;
      wait_for((m >= 2) ? 2 : 1, 12, seen);
      chk("catch start", 16'(m == 1 || m == 2), 16'(seen));
      cyc(12);
      chk("run", 16'h1, 16'(run_enable));
      start_cmd = 1'b0;
      cyc(20);
    end
    motor_speed = 16'h1191;
    cfg.catch_mode = CATCH_ON;
    start_cmd = 1'b1;
    wait_for(5, 20, seen);
    chk("catch fail", 16'h1, 16'(seen));
    do_reset();
    // idle entry, wake, then inhibit
    cfg.idle_entry = 16'h0064;
    cfg.wake_threshold = 16'h00C8;
    cfg.idle_timer = 9'h000;
    {theo_freq, actual_freq} = {2{16'h0032}};
    wait_for(3, 30, seen);
    chk("idle entry", 16'h1, 16'(seen));
    chk("ramp down", 16'h1, 16'(ramp_down));
    chk("run held", 16'h0, 16'(run_enable));
    {theo_freq, actual_freq} = {2{16'h012C}};
    wait_for(4, 30, seen);
    chk("wake", 16'h1, 16'(seen));
    cyc(2);
    chk("target", 16'h012C, freq_target);
    cfg.output_freq_lower_limit = 16'h0190;
    cyc(2);
    chk("target low", 16'h0190, freq_target);
    // open loop enters idle the same way
    cfg.closed_loop = 1'b0;
    {theo_freq, actual_freq} = {2{16'h0032}};
    wait_for(3, 30, seen);
    chk("idle open", 16'h1, 16'(seen));
    chk("boost off", 16'h0064, boost_pct);
    local_ref = 1'b1;
    theo_freq = 16'h0032;
    cyc(40);
    chk("inhibit", 16'h0, 16'(idle_active));
    complete_run();
  end
endmodule
bind dis_supervisor dis_supervisor_props u_dis_supervisor_props (.mclk,
  .rstn, .cfg, .panel_reset_key, .reset_input, .local_ref, .jog, .trip_event,
  .tripped, .trip_clear, .idle_active, .freq_cap, .active_pwm_rate, .derate,
  .attempts_used);
`default_nettype wire
